// file: rtl/high_side_fault_protection.sv
// switch control and fault protection of a high-side power switch
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`default_nettype none
module high_side_fault_protection
  import hs_fault_pkg::*;
#(
  parameter int unsigned ON_DELAY_CYC = TURN_ON_DELAY_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              enable_pin,
  input  wire logic              latch_pin,
  input  wire logic              current_limit_hit,
  input  wire logic [TEMP_W-1:0] fet_temp,
  input  wire logic [TEMP_W-1:0] ctrl_temp,
  output logic                   switch_on,
  output logic                   sense_output,
  output logic                   fault_flag_output_o,
  output logic                   fault_flag_output_oe,
  output logic                   irq
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [2:0]   pins_s;
  logic         enable_s;
  logic         latch_s;
  logic         oc_s;

  sync2 #(.WIDTH(3)) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({current_limit_hit, latch_pin, enable_pin}),
    .sync_out (pins_s)
  );

  assign enable_s = pins_s[0];
  assign latch_s  = pins_s[1];
  assign oc_s     = pins_s[2];

  // ***************************************************************
  // registers and state
  // ***************************************************************
  sw_state_type      state_r;
  logic [CNT_W-1:0]  delay_cnt_r;
  logic [CNT_W-1:0]  retry_cnt_r;
  logic              retry_done_r;
  logic              abs_fault_r;
  logic              rel_fault_r;
  logic              oc_fault_r;
  logic              ctrl_fixed_r;
  logic [TEMP_W-1:0] abs_thr_r;
  logic [TEMP_W-1:0] rel_thr_r;
  logic [TEMP_W-1:0] hys_r;
  logic [EV_W-1:0]   int_status_r;
  logic [EV_W-1:0]   int_mask_r;

  localparam logic [CNT_W-1:0] ON_DELAY_LAST =
    CNT_W'(ON_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYCLES - 1);

  // ***************************************************************
  // fault detection
  // ***************************************************************
  logic              abs_trip;
  logic              rel_trip;
  logic              abs_clear;
  logic              any_fault;
  logic              release_ok;
  logic [TEMP_W:0]   temp_diff;
  logic [TEMP_W:0]   fet_plus_hys;

  // both sensor readings feed the relative check; the absolute check uses fet_temp only
  assign temp_diff    = {1'b0, fet_temp} - {1'b0, ctrl_temp};
  assign fet_plus_hys = {1'b0, fet_temp} + {1'b0, hys_r};

  assign abs_trip  = fet_temp > abs_thr_r;
  assign rel_trip  = (fet_temp > ctrl_temp) &&
                     (temp_diff[TEMP_W-1:0] > rel_thr_r);
  assign abs_clear = fet_plus_hys <= {1'b0, abs_thr_r};

  assign any_fault = abs_fault_r | rel_fault_r | oc_fault_r;
  assign release_ok = !latch_s && retry_done_r && !any_fault;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      abs_fault_r <= 1'b0;
    end else if (abs_trip) begin
      abs_fault_r <= 1'b1;
    end else if (abs_clear) begin
      abs_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rel_fault_r <= 1'b0;
    end else if (rel_trip && !rel_fault_r) begin
      rel_fault_r <= 1'b1;
    end else if (retry_done_r && !rel_trip) begin
      rel_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oc_fault_r <= 1'b0;
    end else if (oc_s) begin
      oc_fault_r <= 1'b1;
    end else if (retry_done_r) begin
      oc_fault_r <= 1'b0;
    end
  end

  // ***************************************************************
  // retry timer
  // ***************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retry_cnt_r  <= '0;
      retry_done_r <= 1'b0;
    end else if (state_r != ST_FAULT) begin
      retry_cnt_r  <= '0;
      retry_done_r <= 1'b0;
    end else if (retry_cnt_r == RETRY_LAST) begin
      retry_done_r <= 1'b1;
    end else begin
      retry_cnt_r <= retry_cnt_r + 1'b1;
    end
  end

  // ***************************************************************
  // switch state machine
  // ***************************************************************
  logic trip;

  assign trip = abs_trip | rel_trip | oc_s;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r     <= ST_OFF;
      delay_cnt_r <= '0;
    end else if (trip && state_r != ST_FAULT) begin
      state_r     <= ST_FAULT;
      delay_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          delay_cnt_r <= '0;
          if (enable_s) begin
            state_r <= ST_ON_WAIT;
          end
        end
        ST_ON_WAIT: begin
          if (!enable_s) begin
            state_r     <= ST_OFF;
            delay_cnt_r <= '0;
          end else if (delay_cnt_r == ON_DELAY_LAST) begin
            state_r     <= ST_ON;
            delay_cnt_r <= '0;
          end else begin
            delay_cnt_r <= delay_cnt_r + 1'b1;
          end
        end
        ST_ON: begin
          delay_cnt_r <= '0;
          if (!enable_s) begin
            state_r <= ST_OFF_WAIT;
          end
        end
        ST_OFF_WAIT: begin
          if (enable_s) begin
            state_r     <= ST_ON;
            delay_cnt_r <= '0;
          end else if (delay_cnt_r == ON_DELAY_LAST) begin
            state_r     <= ST_OFF;
            delay_cnt_r <= '0;
          end else begin
            delay_cnt_r <= delay_cnt_r + 1'b1;
          end
        end
        ST_FAULT: begin
          delay_cnt_r <= '0;
          if (release_ok) begin
            state_r <= ST_OFF;
          end
        end
        default: begin
          state_r     <= ST_OFF;
          delay_cnt_r <= '0;
        end
      endcase
    end
  end

  // ***************************************************************
  // pin outputs
  // ***************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      switch_on <= 1'b0;
    end else begin
      // trip forces switch off at once
      switch_on <= !trip &&
        ((state_r == ST_ON) || (state_r == ST_OFF_WAIT) ||
         (state_r == ST_ON_WAIT && enable_s &&
          delay_cnt_r == ON_DELAY_LAST));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_output         <= 1'b0;
      fault_flag_output_o  <= 1'b0;
      fault_flag_output_oe <= 1'b0;
    end else begin
      sense_output <= trip || (state_r == ST_FAULT && !release_ok);
      fault_flag_output_o <= 1'b0;
      fault_flag_output_oe <= ctrl_fixed_r &&
        (trip || (state_r == ST_FAULT && !release_ok));
    end
  end

  // ***************************************************************
  // events and interrupt
  // ***************************************************************
  logic [EV_W-1:0] events;
  logic            wr_en;
  logic            rd_setup;

  assign events[EV_ABS_BIT]     = abs_trip && !abs_fault_r;
  assign events[EV_REL_BIT]     = rel_trip && !rel_fault_r;
  assign events[EV_OC_BIT]      = oc_s && !oc_fault_r;
  assign events[EV_RELEASE_BIT] = state_r == ST_FAULT && release_ok &&
                                  !trip;

  assign wr_en    = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_status_r <= '0;
    end else if (wr_en && paddr == INT_STATUS_OFS) begin
      int_status_r <= (int_status_r & ~pwdata[EV_W-1:0]) | events;
    end else begin
      int_status_r <= int_status_r | events;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_r & int_mask_r);
    end
  end

  // ***************************************************************
  // apb register file
  // ***************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_fixed_r <= CTRL_FIXED_RST;
      abs_thr_r    <= ABS_THR_RST;
      rel_thr_r    <= REL_THR_RST;
      hys_r        <= HYS_RST;
      int_mask_r   <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        CTRL_OFS:    ctrl_fixed_r <= pwdata[CTRL_FIXED_BIT];
        ABS_THR_OFS: abs_thr_r    <= pwdata[TEMP_W-1:0];
        REL_THR_OFS: rel_thr_r    <= pwdata[TEMP_W-1:0];
        HYS_OFS:     hys_r        <= pwdata[TEMP_W-1:0];
        INT_MASK_OFS: int_mask_r  <= pwdata[EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      CTRL_OFS:       rd_val[CTRL_FIXED_BIT] = ctrl_fixed_r;
      ABS_THR_OFS:    rd_val[TEMP_W-1:0] = abs_thr_r;
      REL_THR_OFS:    rd_val[TEMP_W-1:0] = rel_thr_r;
      HYS_OFS:        rd_val[TEMP_W-1:0] = hys_r;
      STATUS_OFS: begin
        rd_val[STAT_STATE_LSB +: 3] = state_r;
        rd_val[STAT_ABS_BIT]        = abs_fault_r;
        rd_val[STAT_REL_BIT]        = rel_fault_r;
        rd_val[STAT_OC_BIT]         = oc_fault_r;
        rd_val[STAT_ON_BIT]         = switch_on;
      end
      INT_STATUS_OFS: rd_val[EV_W-1:0] = int_status_r;
      INT_MASK_OFS:   rd_val[EV_W-1:0] = int_mask_r;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !rd_hit;
      if (rd_setup) begin
        prdata <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_val;
      end
    end
  end

endmodule : high_side_fault_protection
`default_nettype wire

// file: rtl/hs_fault_pkg.sv
// constants for the high-side switch fault protection block
`default_nettype none
package hs_fault_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ              = 250;
  localparam int unsigned TURN_ON_DELAY_MIN_NS = 20000;
  localparam int unsigned TURN_ON_DELAY_MAX_NS = 100000;
  localparam int unsigned TURN_ON_DELAY_CYC    =
    (TURN_ON_DELAY_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RETRY_NS             = 1000000;
  localparam int unsigned RETRY_CYC            = RETRY_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W                = 20;
  localparam int unsigned TEMP_W               = 10;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] ABS_THR_OFS    = 8'h04;
  localparam logic [7:0] REL_THR_OFS    = 8'h08;
  localparam logic [7:0] HYS_OFS        = 8'h0c;
  localparam logic [7:0] STATUS_OFS     = 8'h10;
  localparam logic [7:0] INT_STATUS_OFS = 8'h14;
  localparam logic [7:0] INT_MASK_OFS   = 8'h18;

  // ***************************************************************
  // fields and reset values
  // ***************************************************************
  localparam int unsigned CTRL_FIXED_BIT  = 0;
  localparam int unsigned EV_ABS_BIT      = 0;
  localparam int unsigned EV_REL_BIT      = 1;
  localparam int unsigned EV_OC_BIT       = 2;
  localparam int unsigned EV_RELEASE_BIT  = 3;
  localparam int unsigned EV_W            = 4;
  localparam int unsigned STAT_STATE_LSB  = 0;
  localparam int unsigned STAT_ABS_BIT    = 4;
  localparam int unsigned STAT_REL_BIT    = 5;
  localparam int unsigned STAT_OC_BIT     = 6;
  localparam int unsigned STAT_ON_BIT     = 7;
  localparam logic [TEMP_W-1:0] ABS_THR_RST = 10'h2bc;
  localparam logic [TEMP_W-1:0] REL_THR_RST = 10'h064;
  localparam logic [TEMP_W-1:0] HYS_RST     = 10'h01e;
  localparam logic               CTRL_FIXED_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_ON_WAIT  = 3'b001,
    ST_ON       = 3'b010,
    ST_OFF_WAIT = 3'b011,
    ST_FAULT    = 3'b100
  } sw_state_type;

endpackage : hs_fault_pkg
`default_nettype wire

// file: rtl/sync2.sv
// two flip-flop synchroniser for asynchronous pin levels
`default_nettype none
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_r <= '0;
      sync_out <= '0;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule : sync2
`default_nettype wire

// file: verification/hs_fault_assertions.sv
// port-level assertions for the switch fault protection block
`default_nettype none
module hs_fault_assertions
  import hs_fault_pkg::*;
#(
  parameter int unsigned ON_DELAY_CYC = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic latch_pin,
  input wire logic current_limit_hit,
  input wire logic switch_on,
  input wire logic sense_output,
  input wire logic fault_flag_output_o,
  input wire logic fault_flag_output_oe
);
  // ***************************************************************
  // sequences
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_trip;
    $rose(sense_output);
  endsequence
  sequence s_latched;
    latch_pin[*4] ##0 sense_output;
  endsequence
  sequence s_at_limit;
    current_limit_hit[*3] ##0 sense_output;
  endsequence

  // ***************************************************************
  // properties
  // ***************************************************************
  a_fault_forces_off: assert property (sense_output |-> !switch_on)
    else $error("switch on during fault");
  a_current_trips: assert property (
    current_limit_hit[*5] |-> sense_output)
    else $error("no fault on current limit");
  a_flag_tracks: assert property (
    fault_flag_output_oe |-> sense_output && !fault_flag_output_o)
    else $error("fault flag without fault");
  a_retry_hold: assert property (s_trip |=> sense_output[*8])
    else $error("fault released before retry");
  a_latch_holds: assert property (s_latched |=> sense_output)
    else $error("fault released with latch high");
  a_limit_persists: assert property (s_at_limit |=> sense_output)
    else $error("fault cleared at current limit");
  a_on_delay: assert property (
    $rose(switch_on) |-> $past(enable_pin, ON_DELAY_CYC))
    else $error("switch on too early");
  a_off_delay: assert property (
    $fell(enable_pin) && switch_on && !current_limit_hit
      |=> switch_on[*4])
    else $error("switch off too early");
endmodule : hs_fault_assertions

bind high_side_fault_protection hs_fault_assertions #(
  .ON_DELAY_CYC(ON_DELAY_CYC)
) u_chk (
  .clk                 (clk),
  .reset               (reset),
  .enable_pin          (enable_pin),
  .latch_pin           (latch_pin),
  .current_limit_hit   (current_limit_hit),
  .switch_on           (switch_on),
  .sense_output        (sense_output),
  .fault_flag_output_o (fault_flag_output_o),
  .fault_flag_output_oe(fault_flag_output_oe)
);
`default_nettype wire

// file: verification/hs_controller_model.sv
// controller model driving the enable and latch pins with a lag
`default_nettype none
module hs_controller_model (
  input  wire logic       clk,
  input  wire logic       req_en,
  input  wire logic       req_latch,
  input  wire logic [1:0] lag,
  output var logic        enable_pin,
  output var logic        latch_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  // pins follow requests lag+1 cycles after they change
  initial begin
    enable_pin = 1'b0;
    latch_pin = 1'b0;
    cnt_r = 2'h0;
    forever begin
      @(posedge clk);
      if ({req_en, req_latch} == {enable_pin, latch_pin}) begin
        cnt_r <= 2'h0;
      end else if (cnt_r == lag) begin
        enable_pin <= req_en;
        latch_pin <= req_latch;
        cnt_r <= 2'h0;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end
endmodule : hs_controller_model
`default_nettype wire

// file: verification/high_side_fault_protection_tb.sv
// self-checking bench for the switch fault protection block
`default_nettype none
module high_side_fault_protection_tb
  import hs_fault_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define chk(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected %0t: got %h want %h", $time, a, b); end end
  logic              clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              current_limit_hit, switch_on, sense_output, irq;
  logic              flag_o, flag_oe, enable_pin, latch_pin;
  logic              req_en, req_latch;
  logic [1:0]        lag;
  logic [TEMP_W-1:0] fet_temp, ctrl_temp;
  logic [32:0]       exp_q[$];
  logic [31:0]       rst_tab [8];
  int                fail_count, checks, n;
  integer            seed;

  high_side_fault_protection #(.ON_DELAY_CYC(8), .RETRY_CYCLES(16)) dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .latch_pin(latch_pin), .current_limit_hit(current_limit_hit),
    .fet_temp(fet_temp), .ctrl_temp(ctrl_temp), .switch_on(switch_on),
    .sense_output(sense_output), .fault_flag_output_o(flag_o),
    .fault_flag_output_oe(flag_oe), .irq(irq));
  hs_controller_model ctl (.clk(clk), .req_en(req_en),
    .req_latch(req_latch), .lag(lag), .enable_pin(enable_pin),
    .latch_pin(latch_pin));

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    if (!wr) exp_q.push_back({err, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_lvl(input logic on_sel, input logic v);
    n = 0;
    while ((on_sel ? switch_on : sense_output) !== v && n < 400) begin
      n++;
      @(posedge clk);
    end
    if (n == 400) begin
      fail_count++;
      $display("unexpected %0t: level wait timed out", $time);
    end
  endtask : wait_lvl
  task automatic stop_test();
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ***************************************************************
  // clock, monitor, watchdog
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      `chk({pslverr, prdata}, exp_q.pop_front())
    end
  end
  initial begin
    #40000;
    fail_count++;
    $display("unexpected %0t: watchdog expired", $time);
    stop_test();
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial begin
    seed = 32'hb45c;
    rst_tab = '{32'h0, {22'h0, ABS_THR_RST}, {22'h0, REL_THR_RST},
      {22'h0, HYS_RST}, 32'h0, 32'h0, 32'h0, 32'h0};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {current_limit_hit, req_en, req_latch, lag} = '0;
    n = $random(seed);
    fet_temp = {2'h0, n[7:0]};
    ctrl_temp = {1'b0, n[8:0]} | 10'h100;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) apb(1'b0, 8'(i * 4), rst_tab[i], i == 7);
    apb(1'b1, CTRL_OFS, 32'h1, 1'b0);
    apb(1'b1, INT_MASK_OFS, 32'hf, 1'b0);
    lag <= 2'($random(seed));
    req_en <= 1'b1;
    wait_lvl(1'b1, 1'b1);
    `chk(n > 8 && n < 24, 1'b1)
    apb(1'b0, STATUS_OFS, 32'h82, 1'b0);
    req_en <= 1'b0;
    wait_lvl(1'b1, 1'b0);
    `chk(n > 8 && n < 24, 1'b1)
    apb(1'b0, STATUS_OFS, 32'h0, 1'b0);
    req_en <= 1'b1;
    wait_lvl(1'b1, 1'b1);
    `chk(n > 8 && n < 24, 1'b1)
    current_limit_hit <= 1'b1;
    wait_lvl(1'b0, 1'b1);
    `chk({switch_on, sense_output}, 2'b01)
    `chk({switch_on, flag_o, flag_oe}, 3'b001)
    apb(1'b0, STATUS_OFS, 32'h44, 1'b0);
    apb(1'b0, INT_STATUS_OFS, 32'h4, 1'b0);
    `chk(irq, 1'b1)
    apb(1'b1, INT_STATUS_OFS, 32'h4, 1'b0);
    lag <= 2'($random(seed));
    req_latch <= 1'b1;
    repeat (8) @(posedge clk);
    {req_en, current_limit_hit} <= 2'b00;
    repeat (40) @(posedge clk);
    `chk({irq, sense_output, flag_oe}, 3'b011)
    apb(1'b0, STATUS_OFS, 32'h04, 1'b0);
    req_latch <= 1'b0;
    wait_lvl(1'b0, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0, 1'b0);
    apb(1'b0, INT_STATUS_OFS, 32'h8, 1'b0);
    apb(1'b1, INT_STATUS_OFS, 32'h8, 1'b0);
    ctrl_temp <= 10'h290;
    fet_temp <= 10'h2bd;
    wait_lvl(1'b0, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h14, 1'b0);
    fet_temp <= 10'h29f;
    repeat (40) @(posedge clk);
    `chk(sense_output, 1'b1)
    fet_temp <= 10'h29e;
    wait_lvl(1'b0, 1'b0);
    apb(1'b0, INT_STATUS_OFS, 32'h9, 1'b0);
    apb(1'b1, INT_STATUS_OFS, 32'h9, 1'b0);
    apb(1'b1, INT_MASK_OFS, 32'h0, 1'b0);
    n = $random(seed);
    fet_temp <= 10'h200;
    ctrl_temp <= 10'h19b - {3'h0, n[6:0]};
    wait_lvl(1'b0, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h24, 1'b0);
    `chk(irq, 1'b0)
    ctrl_temp <= 10'h200;
    wait_lvl(1'b0, 1'b0);
    `chk(n > 8, 1'b1)
    apb(1'b0, INT_STATUS_OFS, 32'ha, 1'b0);
    stop_test();
  end
endmodule : high_side_fault_protection_tb
`default_nettype wire
